// file: hw/tui_irq_top.sv
// Time-update and calendar-alarm interrupt logic with Avalon-MM registers
// ----------------------------------------------------------------
// What this block does
// - Select bits hi,lo: 00 second, 01 minute, 10 hour carry, 11 none.
// - The selected counter carry sets the time-update flag.
// - With update enable set at that moment, the interrupt pin goes low.
// - Update interrupt releases itself 7.812 ms after the pin went low.
// - Writing 0 to update enable releases the pin immediately.
// - Auto release keeps the update flag; only a host 0 write clears it.
// - Writing 0 to the update flag releases the pin at once.
// - Second/minute fields: 3-bit tens, 4-bit units, exclude; hour 2-bit tens.
// - Day mode 0: weekday mask bit0 Sunday; mode 1: BCD day of month.
// - Minute, hour and day compares also reachable at mirror offsets.
// - An excluded field takes no part in the comparison.
// - All four excluded: the alarm matches on every second update.
// - Seconds excluded: alarm fires every second of the matching minute.
// - Full match sets the alarm flag; with alarm enable set, pin goes low.
// - Alarm flag clears only on a host 0 write to the flag; the pin also on alarm enable 0.
// - Writing 0 to alarm enable releases the pin whatever the flag.
// ----------------------------------------------------------------
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module tui_irq_top
   import tui_pkg::*;
#(
   parameter int RELEASE_CYCLES = AUTO_RELEASE_CYCLES
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Clock counter events and values
   input wire logic i_sec_carry,
   input wire logic i_min_carry,
   input wire logic i_hour_carry,
   input wire logic i_second_tick,
   input wire logic [SEC_W-1:0] i_cur_sec,
   input wire logic [SEC_W-1:0] i_cur_min,
   input wire logic [HOUR_W-1:0] i_cur_hour,
   input wire logic [WDAY_W-1:0] i_cur_weekday,
   input wire logic [DATE_W-1:0] i_cur_day,
   // Open-drain interrupt pin, active low
   output logic o_irq_n_out,
   output logic o_irq_oe,
   // Counter enable toward the clock counters
   output logic o_bcd_counter_enable
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [7:0] alarm_second_compare_ff, alarm_minute_compare_ff, alarm_hour_compare_ff, alm_day_ff;
   logic [3:0] ctrl_ff;
   logic uie_ff, aie_ff, uf_ff, af_ff;
   logic ureq_ff, areq_ff, oe_ff, out_ff;
   logic [REL_CNT_W-1:0] rel_cnt_ff;
   logic [REL_CNT_W-1:0] nxt_rel_cnt;
   logic nxt_wait, nxt_uf, nxt_af, nxt_ureq, nxt_areq;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // One wait state: keeps read data registered at a fixed answer time
   wire bus_req = i_avs_read | i_avs_write;
   wire wr_go = i_avs_write & ~wait_ff;
   wire rd_take = i_avs_read & wait_ff;
   wire hit_sec = i_avs_address == OFS_ALARM_SECOND_COMPARE;
   wire hit_min = (i_avs_address == OFS_ALARM_MINUTE_COMPARE) | (i_avs_address == OFS_ALARM_MINUTE_MIRROR);
   wire hit_hour = (i_avs_address == OFS_ALARM_HOUR_COMPARE) | (i_avs_address == OFS_ALARM_HOUR_MIRROR);
   wire hit_day = (i_avs_address == OFS_ALM_DAY) | (i_avs_address == OFS_ALM_DAY_MIR);
   wire hit_ctrl = i_avs_address == OFS_CTRL;
   wire hit_en = i_avs_address == OFS_IRQ_EN;
   wire hit_flag = i_avs_address == OFS_IRQ_FLAG;
   wire wr_en = wr_go & hit_en;
   wire wr_flag = wr_go & hit_flag;
   // Only a written 0 clears; a written 1 leaves a flag alone
   wire uf_clr = wr_flag & ~i_avs_writedata[BIT_UPD];
   wire af_clr = wr_flag & ~i_avs_writedata[BIT_ALM];
   wire uie_off = wr_en & ~i_avs_writedata[BIT_UPD];
   wire aie_off = wr_en & ~i_avs_writedata[BIT_ALM];
   wire [31:0] rd_mux = hit_sec ? {24'h000000, alarm_second_compare_ff} :
                        hit_min ? {24'h000000, alarm_minute_compare_ff} :
                        hit_hour ? {24'h000000, alarm_hour_compare_ff} :
                        hit_day ? {24'h000000, alm_day_ff} :
                        hit_ctrl ? {28'h0000000, ctrl_ff} :
                        hit_en ? {30'h00000000, aie_ff, uie_ff} :
                        hit_flag ? {29'h00000000, oe_ff, af_ff, uf_ff} :
                        32'h00000000;

   // ----------------------------------------------------------------
   // Update event
   // ----------------------------------------------------------------
   wire bcd_en = ctrl_ff[BIT_BCD_EN];
   wire [1:0] upd_sel = {ctrl_ff[BIT_SEL_HI], ctrl_ff[BIT_SEL_LO]};
   wire sel_carry = (upd_sel == SEL_SECOND) ? i_sec_carry :
                    (upd_sel == SEL_MINUTE) ? i_min_carry :
                    (upd_sel == SEL_HOUR) ? i_hour_carry : 1'b0;
   wire upd_evt = sel_carry & bcd_en;
   wire upd_fire = upd_evt & uie_ff;
   wire timeout = ureq_ff & (rel_cnt_ff == REL_CNT_W'(RELEASE_CYCLES - 1));

   // ----------------------------------------------------------------
   // Alarm compare
   // ----------------------------------------------------------------
   logic m_sec, m_min, m_hour;
   tui_field_match #(.W(SEC_W)) u_match_sec (
      .i_alarm(alarm_second_compare_ff[SEC_W-1:0]),
      .i_now(i_cur_sec),
      .i_exclude(alarm_second_compare_ff[BIT_EXCL]),
      .o_match(m_sec)
   );
   tui_field_match #(.W(SEC_W)) u_match_min (
      .i_alarm(alarm_minute_compare_ff[SEC_W-1:0]),
      .i_now(i_cur_min),
      .i_exclude(alarm_minute_compare_ff[BIT_EXCL]),
      .o_match(m_min)
   );
   tui_field_match #(.W(HOUR_W)) u_match_hour (
      .i_alarm(alarm_hour_compare_ff[HOUR_W-1:0]),
      .i_now(i_cur_hour),
      .i_exclude(alarm_hour_compare_ff[BIT_EXCL]),
      .o_match(m_hour)
   );
   // Weekday mask may name several days at once
   wire wday_hit = |(alm_day_ff[WDAY_W-1:0] & i_cur_weekday);
   wire date_hit = alm_day_ff[DATE_W-1:0] == i_cur_day;
   wire day_val = ctrl_ff[BIT_DAY_MODE] ? date_hit : wday_hit;
   wire m_day = alm_day_ff[BIT_EXCL] | day_val;
   // Evaluated on each second tick, so an open seconds field repeats
   wire alm_evt = i_second_tick & bcd_en & m_sec & m_min & m_hour & m_day;
   wire alm_fire = alm_evt & aie_ff;

   // ----------------------------------------------------------------
   // Next-state terms
   // ----------------------------------------------------------------
   // Hardware set wins over a same-cycle software clear
   assign nxt_uf = upd_evt | (uf_ff & ~uf_clr);
   assign nxt_af = alm_evt | (af_ff & ~af_clr);
   assign nxt_ureq = upd_fire | (ureq_ff & ~uf_clr & ~uie_off & ~timeout);
   assign nxt_areq = alm_fire | (areq_ff & ~af_clr & ~aie_off);
   // Timer restarts when the pin newly goes low or re-fires at its release edge
   assign nxt_rel_cnt = (upd_fire & (~ureq_ff | timeout)) ? '0 :
                        ureq_ff ? REL_CNT_W'(rel_cnt_ff + 1'b1) : rel_cnt_ff;
   assign nxt_wait = ~(bus_req & wait_ff);

   // ----------------------------------------------------------------
   // Bus slave state
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
      end else begin
         wait_ff <= nxt_wait;
         if (rd_take) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         alarm_second_compare_ff <= ALM_RESET;
         alarm_minute_compare_ff <= ALM_RESET;
         alarm_hour_compare_ff <= ALM_RESET;
         alm_day_ff <= ALM_RESET;
         ctrl_ff <= CTRL_RESET;
         uie_ff <= 1'b0;
         aie_ff <= 1'b0;
      end else if (wr_go) begin
         if (hit_sec) begin
            alarm_second_compare_ff <= i_avs_writedata[7:0];
         end
         if (hit_min) begin
            alarm_minute_compare_ff <= i_avs_writedata[7:0];
         end
         if (hit_hour) begin
            alarm_hour_compare_ff <= i_avs_writedata[7:0];
         end
         if (hit_day) begin
            alm_day_ff <= i_avs_writedata[7:0];
         end
         if (hit_ctrl) begin
            ctrl_ff <= i_avs_writedata[3:0];
         end
         if (hit_en) begin
            uie_ff <= i_avs_writedata[BIT_UPD];
            aie_ff <= i_avs_writedata[BIT_ALM];
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags, requests and pin
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         uf_ff <= 1'b0;
         af_ff <= 1'b0;
         ureq_ff <= 1'b0;
         areq_ff <= 1'b0;
         rel_cnt_ff <= '0;
         oe_ff <= 1'b0;
         out_ff <= 1'b0;
      end else begin
         uf_ff <= nxt_uf;
         af_ff <= nxt_af;
         ureq_ff <= nxt_ureq;
         areq_ff <= nxt_areq;
         rel_cnt_ff <= nxt_rel_cnt;
         oe_ff <= nxt_ureq | nxt_areq;
         out_ff <= 1'b0;
      end
   end

   assign o_avs_waitrequest = wait_ff;
   assign o_avs_readdata = rdata_ff;
   assign o_irq_oe = oe_ff;
   assign o_irq_n_out = out_ff;
   assign o_bcd_counter_enable = ctrl_ff[BIT_BCD_EN];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   property p_sel_none;
      (upd_sel == SEL_NONE) |-> !upd_evt;
   endproperty
   a_sel_none: assert property (p_sel_none) else $error("update event with select 11");

   property p_uf_set;
      upd_evt |=> uf_ff;
   endproperty
   a_uf_set: assert property (p_uf_set) else $error("update flag not set");

   property p_pin_on;
      (upd_evt && uie_ff) |=> o_irq_oe && ureq_ff;
   endproperty
   a_pin_on: assert property (p_pin_on) else $error("pin not driven on update");

   property p_rel_bound;
      ureq_ff |-> (rel_cnt_ff < REL_CNT_W'(RELEASE_CYCLES));
   endproperty
   a_rel_bound: assert property (p_rel_bound) else $error("update request outlived release time");

   property p_rel_end;
      (timeout && !upd_fire) |=> !ureq_ff;
   endproperty
   a_rel_end: assert property (p_rel_end) else $error("auto release missed");

   property p_uie_off;
      (uie_off && !upd_fire) |=> !ureq_ff;
   endproperty
   a_uie_off: assert property (p_uie_off) else $error("enable 0 did not release");

   property p_uf_keep;
      (timeout && !uf_clr && !upd_fire) |=> uf_ff && !ureq_ff;
   endproperty
   a_uf_keep: assert property (p_uf_keep) else $error("auto release lost the flag");

   property p_uf_clr;
      (uf_clr && !upd_evt) |=> !uf_ff && !ureq_ff;
   endproperty
   a_uf_clr: assert property (p_uf_clr) else $error("flag clear did not release");

   property p_all_excl;
      (i_second_tick && bcd_en && alarm_second_compare_ff[BIT_EXCL] && alarm_minute_compare_ff[BIT_EXCL] && alarm_hour_compare_ff[BIT_EXCL]
         && alm_day_ff[BIT_EXCL]) |=> af_ff;
   endproperty
   a_all_excl: assert property (p_all_excl) else $error("all-excluded alarm missed");

   property p_alm_pin;
      alm_fire |=> areq_ff ##0 o_irq_oe;
   endproperty
   a_alm_pin: assert property (p_alm_pin) else $error("alarm did not drive pin");

   property p_af_clr;
      (af_clr && !alm_evt) |=> !af_ff && !areq_ff;
   endproperty
   a_af_clr: assert property (p_af_clr) else $error("alarm clear did not release");

   property p_aie_off;
      (aie_off && !alm_fire) |=> !areq_ff;
   endproperty
   a_aie_off: assert property (p_aie_off) else $error("alarm enable 0 did not release");

   property p_pin_join;
      o_irq_oe == (ureq_ff || areq_ff);
   endproperty
   a_pin_join: assert property (p_pin_join) else $error("pin not the union of requests");

   c_upd_timeout: cover property (timeout);
   c_alarm_fire: cover property (alm_fire);
   c_both_req: cover property (ureq_ff && areq_ff);
   c_mirror_wr: cover property (wr_go && (i_avs_address == OFS_ALM_DAY_MIR));
endmodule : tui_irq_top

// file: inc/tui_pkg.sv
// Constants shared by the time-update and alarm interrupt block
package tui_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] OFS_ALARM_SECOND_COMPARE = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_ALARM_MINUTE_COMPARE = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_ALARM_HOUR_COMPARE = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_ALM_DAY = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_ALARM_MINUTE_MIRROR = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_ALARM_HOUR_MIRROR = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_ALM_DAY_MIR = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 6'h24;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_EXCL = 7;
   localparam int BIT_SEL_LO = 0;
   localparam int BIT_SEL_HI = 1;
   localparam int BIT_DAY_MODE = 2;
   localparam int BIT_BCD_EN = 3;
   localparam int BIT_UPD = 0;
   localparam int BIT_ALM = 1;
   localparam int BIT_PIN = 2;
   localparam int SEC_W = 7;
   localparam int HOUR_W = 6;
   localparam int WDAY_W = 7;
   localparam int DATE_W = 6;
   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] ALM_RESET = 8'h00;
   localparam logic [3:0] CTRL_RESET = 4'h8;
   localparam logic [1:0] SEL_SECOND = 2'h0;
   localparam logic [1:0] SEL_MINUTE = 2'h1;
   localparam logic [1:0] SEL_HOUR = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int AUTO_RELEASE_TIME_NS = 7812000;
   localparam int AUTO_RELEASE_CYCLES = AUTO_RELEASE_TIME_NS / CLOCK_PERIOD_NS;
   localparam int REL_CNT_W = 18;
endpackage : tui_pkg

// file: hw/tui_field_match.sv
// One alarm compare field with its exclude bit
`timescale 1ns/100ps
module tui_field_match #(
   parameter int W = 7
) (
   // Compare inputs
   input wire logic [W-1:0] i_alarm,
   input wire logic [W-1:0] i_now,
   input wire logic i_exclude,
   // Result
   output logic o_match
);
   assign o_match = i_exclude | (i_alarm == i_now);
endmodule : tui_field_match

// file: verification/tui_host_model.sv
// Host side of the open-drain interrupt line
`timescale 1ns/100ps
module tui_host_model (
   // Pin from the device
   input wire logic i_irq_oe,
   input wire logic i_irq_n_out,
   // Level the host sees
   output logic o_irq_line
);
   // Pull-up wins when released, so a stale low never lingers
   assign o_irq_line = i_irq_oe ? i_irq_n_out : 1'b1;
endmodule : tui_host_model

// file: verification/tui_irq_top_test.sv
// Self-checking bench for the interrupt block
`timescale 1ns/100ps
module tui_irq_top_test;
   import tui_pkg::*;
   localparam int REL = 20;
   logic i_clock, i_rst_n, rd, wr, waitreq, tick, irq_n_out, irq_oe, bcd_en, irq_line;
   logic [ADDR_W-1:0] adr;
   logic [31:0] wdata, rdata, q;
   logic [2:0] carry;
   logic [SEC_W-1:0] c_sec, c_min;
   logic [HOUR_W-1:0] c_hour;
   logic [WDAY_W-1:0] c_wday;
   logic [DATE_W-1:0] c_day;
   int mismatches, cmp_count;
   tui_irq_top #(.RELEASE_CYCLES(REL)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_sec_carry(carry[0]), .i_min_carry(carry[1]), .i_hour_carry(carry[2]),
      .i_second_tick(tick), .i_cur_sec(c_sec), .i_cur_min(c_min), .i_cur_hour(c_hour),
      .i_cur_weekday(c_wday), .i_cur_day(c_day), .o_irq_n_out(irq_n_out), .o_irq_oe(irq_oe),
      .o_bcd_counter_enable(bcd_en));
   tui_host_model i_host (.i_irq_oe(irq_oe), .i_irq_n_out(irq_n_out), .o_irq_line(irq_line));
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic bus(input logic r, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge i_clock);
      adr <= a;
      wdata <= d;
      rd <= r;
      wr <= !r;
      // No answer time assumed: only the watchdog ends a hung wait
      do begin
         @(posedge i_clock);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0);
      chk(q, e);
   endtask : rdchk
   task automatic ev(input int c);
      @(posedge i_clock);
      if (c < 3) carry[c] <= 1'b1;
      else tick <= 1'b1;
      @(posedge i_clock);
      carry <= 3'h0;
      tick <= 1'b0;
   endtask : ev
   task automatic alm(input logic [7:0] s, m, h, d, input logic md, input logic [6:0] cs, cm,
      input logic [5:0] ch, input logic [6:0] cw, input logic [5:0] cd, input logic e, input logic by_en);
      bus(1'b0, OFS_IRQ_EN, 32'h0);
      bus(1'b0, OFS_ALARM_SECOND_COMPARE, 32'(s));
      bus(1'b0, OFS_ALARM_MINUTE_MIRROR, 32'(m));
      bus(1'b0, OFS_ALARM_HOUR_COMPARE, 32'(h));
      bus(1'b0, OFS_ALM_DAY_MIR, 32'(d));
      bus(1'b0, OFS_CTRL, {28'h0, 1'b1, md, 2'h3});
      bus(1'b0, OFS_IRQ_FLAG, 32'h0);
      bus(1'b0, OFS_IRQ_EN, 32'h2);
      rdchk(OFS_ALARM_MINUTE_COMPARE, 32'(m));
      rdchk(OFS_ALM_DAY, 32'(d));
      c_sec <= cs;
      c_min <= cm;
      c_hour <= ch;
      c_wday <= cw;
      c_day <= cd;
      ev(3);
      @(posedge i_clock);
      chk(32'(irq_line), 32'(!e));
      rdchk(OFS_IRQ_FLAG, {29'h0, e, e, 1'b0});
      if (e) begin
         if (by_en) begin
            bus(1'b0, OFS_IRQ_EN, 32'h0);
            repeat (2) @(posedge i_clock);
            chk(32'(irq_line), 32'h1);
            rdchk(OFS_IRQ_FLAG, 32'h2);
         end
         bus(1'b0, OFS_IRQ_FLAG, 32'h0);
         repeat (2) @(posedge i_clock);
         chk(32'(irq_line), 32'h1);
         rdchk(OFS_IRQ_FLAG, 32'h0);
      end
   endtask : alm
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   initial begin
      // Whole run needs well under a thousand cycles
      repeat (5000) @(posedge i_clock);
      mismatches++;
      test_done();
   end
   initial begin
      {i_rst_n, rd, wr, tick, carry, adr, wdata} = '0;
      {c_sec, c_min, c_hour, c_wday, c_day} = '0;
      mismatches = 0;
      cmp_count = 0;
      repeat (20) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      chk(32'(bcd_en), 32'h1);
      bus(1'b0, 6'h28, 32'hFFFFFFFF);
      for (int a = 0; a <= 40; a += 4) rdchk(ADDR_W'(a), (a == 28) ? 32'h8 : 32'h0);
      for (int s = 0; s < 4; s++) begin
         bus(1'b0, OFS_IRQ_EN, 32'h0);
         bus(1'b0, OFS_CTRL, 32'h8 | 32'(s));
         bus(1'b0, OFS_IRQ_FLAG, 32'h0);
         bus(1'b0, OFS_IRQ_EN, 32'h1);
         for (int c = 0; c < 3; c++) begin
            ev(c);
            rdchk(OFS_IRQ_FLAG, (s != 3 && c >= s) ? 32'h5 : 32'h0);
            chk(32'(q[0]), 32'(s != 3 && c >= s));
         end
         if (s < 3) begin
            bus(1'b0, OFS_IRQ_FLAG, 32'h0);
            ev(s);
            @(posedge i_clock);
            chk(32'(irq_line), 32'h0);
            if (s == 0) begin
               repeat (REL - 2) @(posedge i_clock);
               chk(32'(irq_line), 32'h0);
               repeat (2) @(posedge i_clock);
               chk(32'(irq_line), 32'h1);
               rdchk(OFS_IRQ_FLAG, 32'h1);
            end else if (s == 1) begin
               bus(1'b0, OFS_IRQ_FLAG, 32'h0);
               repeat (2) @(posedge i_clock);
               chk(32'(irq_line), 32'h1);
            end else begin
               bus(1'b0, OFS_IRQ_EN, 32'h0);
               repeat (2) @(posedge i_clock);
               chk(32'(irq_line), 32'h1);
               rdchk(OFS_IRQ_FLAG, 32'h1);
            end
         end else begin
            chk(32'(irq_line), 32'h1);
         end
      end
      bus(1'b0, OFS_IRQ_EN, 32'h0);
      bus(1'b0, OFS_IRQ_FLAG, 32'h0);
      alm(8'h80, 8'h80, 8'h80, 8'h80, 1'b0, 7'h12, 7'h34, 6'h05, 7'h01, 6'h03, 1'b1, 1'b0);
      alm(8'h80, 8'h00, 8'h07, 8'h3E, 1'b0, 7'h37, 7'h00, 6'h07, 7'h02, 6'h01, 1'b1, 1'b1);
      alm(8'h80, 8'h00, 8'h07, 8'h3E, 1'b0, 7'h37, 7'h00, 6'h07, 7'h01, 6'h01, 1'b0, 1'b0);
      alm(8'h00, 8'h30, 8'h80, 8'h15, 1'b1, 7'h00, 7'h30, 6'h22, 7'h10, 6'h15, 1'b1, 1'b0);
      alm(8'h00, 8'h30, 8'h80, 8'h15, 1'b1, 7'h00, 7'h30, 6'h22, 7'h10, 6'h14, 1'b0, 1'b0);
      alm(8'h30, 8'h59, 8'h18, 8'h80, 1'b0, 7'h31, 7'h59, 6'h18, 7'h08, 6'h09, 1'b0, 1'b0);
      alm(8'h30, 8'h59, 8'h18, 8'h80, 1'b0, 7'h30, 7'h59, 6'h18, 7'h08, 6'h09, 1'b1, 1'b1);
      test_done();
   end
endmodule : tui_irq_top_test
